// ---- src/aasq_top.sv ----
// Autoscan converter sequencer: control word, slot timer, mux steering,
// converter strobes and 32-word result store behind an AHB-Lite slave.
// Assumes converter data inputs arrive asynchronously and are synchronised.
`timescale 1ns/1ps
// How it works
// - Scan channels in turn every 10.05 us
// - Scan size selects sixteen or eight channels
// - Roughly 41 ms calibration after any reset
// - Reset clears control word, scanning off
// - Store each 16-bit result at channel word
// - Host reads never disturb scan timing
// - Repeat mode converts one chosen channel
// - Hold, then advance mux during conversion
// - Store each result in the last cycle of its slot
// - Format select, fail indicator, software reset bits
// - Thirty-two 16-bit host accessible words
// - Lower sixteen words hold channel results
// - Control word at first eight even offsets
module aasq_top #(
  parameter int CAL_CYCLES = aasq_pkg::CAL_CYC,
  parameter int SLOT_CYCLES = aasq_pkg::SLOT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter and front end
  output logic [3:0] mux_sel,
  output logic adc_hold,
  output logic adc_convert,
  output logic adc_cal_start,
  input wire logic [15:0] adc_data,
  output logic fmt_twos,
  output logic fail_led
);
  localparam int CW = $clog2(CAL_CYCLES + 1);
  localparam int SW = $clog2(SLOT_CYCLES + 1);

  // ==========================================================
  // Synchroniser for converter data
  logic [15:0] adc_s1_q, adc_s2_q;
  always_ff @(posedge clk) begin
    adc_s1_q <= adc_data;
    adc_s2_q <= adc_s1_q;
  end

  // ==========================================================
  // Bus address phase capture
  // Offsets are word indices: byte address bits 9:2 pick the register,
  // bits above 9 are not decoded, so the map repeats every 1 KiB
  logic ap_valid_d, ap_valid_q, ap_write_d, ap_write_q;
  logic [7:0] ap_addr_d, ap_addr_q;
  always_comb begin
    ap_valid_d = hsel && hready && htrans[1];
    ap_write_d = hwrite;
    ap_addr_d = haddr[9:2];
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ap_valid_q <= ap_valid_d;
      ap_write_q <= ap_write_d;
      ap_addr_q <= ap_addr_d;
    end
  end
  logic hit_ctl, hit_ram, wr_ctl, wr_ram;
  always_comb begin
    hit_ctl = ap_addr_q <= aasq_pkg::CTL_HI && !ap_addr_q[0];
    hit_ram = ap_addr_q >= aasq_pkg::RAM_LO && ap_addr_q <= aasq_pkg::RAM_HI
      && !ap_addr_q[0];
    wr_ctl = ap_valid_q && ap_write_q && hit_ctl;
    wr_ram = ap_valid_q && ap_write_q && hit_ram;
  end
  // Word index: even register offsets from 0x10, halved
  logic [4:0] ram_idx;
  always_comb begin
    ram_idx = 5'(({24'h00_0000, ap_addr_q} - 32'(aasq_pkg::RAM_LO)) >> 1);
  end

  // ==========================================================
  // Control word
  logic [15:0] ctl_d, ctl_q;
  logic soft_rst;
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d = hwdata[15:0];
    end
    // Software reset clears the whole control word, not even its own bit survives
    soft_rst = wr_ctl && hwdata[aasq_pkg::B_SWRST];
    if (soft_rst) begin
      ctl_d = aasq_pkg::CTL_RESET;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctl_q <= aasq_pkg::CTL_RESET;
    end else begin
      ctl_q <= ctl_d;
    end
  end
  logic scan_en, size8, repeat_en;
  logic [3:0] repeat_ch;
  always_comb begin
    scan_en = ctl_q[aasq_pkg::B_SCAN_EN];
    size8 = ctl_q[aasq_pkg::B_SIZE8];
    repeat_en = ctl_q[aasq_pkg::B_REPEAT];
    repeat_ch = ctl_q[aasq_pkg::B_SEL_LO +: aasq_pkg::SEL_W];
  end

  // ==========================================================
  // Sequencer
  aasq_pkg::aasq_state_t st_d, st_q;
  logic [CW-1:0] cal_d, cal_q;
  logic [SW-1:0] slot_d, slot_q;
  logic [3:0] ch_d, ch_q, prev_d, prev_q;
  logic pend_d, pend_q, store;
  logic slot_end;
  always_comb begin
    st_d = st_q;
    cal_d = cal_q;
    slot_d = slot_q;
    ch_d = ch_q;
    prev_d = prev_q;
    pend_d = pend_q;
    store = 1'b0;
    slot_end = slot_q == SW'(SLOT_CYCLES - 1);
    case (st_q)
      aasq_pkg::ST_CAL: begin
        // Requests wait here until the converter is calibrated
        if (cal_q == CW'(CAL_CYCLES - 1)) begin
          st_d = aasq_pkg::ST_IDLE;
        end else begin
          cal_d = cal_q + CW'(1);
        end
      end
      aasq_pkg::ST_IDLE: begin
        // Mux preset here so the first slot samples a settled input
        slot_d = '0;
        pend_d = 1'b0;
        ch_d = repeat_en ? repeat_ch : 4'h0;
        if (scan_en || repeat_en) begin
          st_d = aasq_pkg::ST_RUN;
        end
      end
      aasq_pkg::ST_RUN: begin
        slot_d = slot_end ? '0 : slot_q + SW'(1);
        if (slot_end) begin
          // Result of the channel converted in this slot lands in its last cycle, before the next convert
          store = pend_q;
          prev_d = ch_q;
          pend_d = 1'b1;
          if (repeat_en) begin
            ch_d = repeat_ch;
          end else if ((size8 && ch_q == 4'h7) || ch_q == 4'hF) begin
            ch_d = 4'h0;
          end else begin
            ch_d = ch_q + 4'h1;
          end
        end
        // Stop only at a slot boundary so a started conversion is never cut
        if (slot_end && !scan_en && !repeat_en) begin
          st_d = aasq_pkg::ST_IDLE;
        end
      end
      default: st_d = aasq_pkg::ST_CAL;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!nrst || soft_rst) begin
      st_q <= aasq_pkg::ST_CAL;
      cal_q <= '0;
      slot_q <= '0;
      ch_q <= 4'h0;
      prev_q <= 4'h0;
      pend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cal_q <= cal_d;
      slot_q <= slot_d;
      ch_q <= ch_d;
      prev_q <= prev_d;
      pend_q <= pend_d;
    end
  end

  // ==========================================================
  // Converter strobes: hold at slot start, then mux advances
  logic hold_d, hold_q, conv_d, conv_q, calp_d, calp_q;
  logic [3:0] mux_d, mux_q;
  always_comb begin
    hold_d = st_q == aasq_pkg::ST_RUN && slot_q < SW'(aasq_pkg::HOLD_CYC);
    conv_d = st_q == aasq_pkg::ST_RUN && slot_q == '0;
    // Mux moves to next channel once hold has taken the sample
    mux_d = (st_q == aasq_pkg::ST_RUN && slot_q == SW'(aasq_pkg::HOLD_CYC))
      ? ch_d : mux_q;
    if (st_q == aasq_pkg::ST_IDLE) begin
      mux_d = ch_d;
    end
    calp_d = st_q == aasq_pkg::ST_CAL && cal_q == '0;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold_q <= 1'b0;
      conv_q <= 1'b0;
      mux_q <= 4'h0;
      calp_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      conv_q <= conv_d;
      mux_q <= mux_d;
      calp_q <= calp_d;
    end
  end

  // ==========================================================
  // Result store: one write port shared by sequencer and host
  // A finished result must land on time, so it wins a clash and the
  // host write of that cycle is lost; host tests run with scanning off
  logic [15:0] ram_q [aasq_pkg::RAM_WORDS];
  logic ram_we;
  logic [4:0] ram_wa;
  logic [15:0] ram_wd;
  always_comb begin
    ram_we = store || wr_ram;
    ram_wa = ram_idx;
    ram_wd = hwdata[15:0];
    if (store) begin
      ram_wa = {1'b0, prev_q};
      ram_wd = adc_s2_q;
    end
  end
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_q[ram_wa] <= ram_wd;
    end
  end

  // ==========================================================
  // Read data: store reads never stall the sequencer
  // Looked up in the address phase so hrdata stands for the data phase
  logic [7:0] rd_idx;
  logic rd_ctl, rd_ram;
  logic [4:0] rd_word;
  logic [31:0] status_w, rd_d, rd_q;
  always_comb begin
    rd_idx = haddr[9:2];
    // Odd indices and the reserved range read as zero
    rd_ctl = rd_idx <= aasq_pkg::CTL_HI && !rd_idx[0];
    rd_ram = rd_idx >= aasq_pkg::RAM_LO && rd_idx <= aasq_pkg::RAM_HI && !rd_idx[0];
    rd_word = 5'((rd_idx - aasq_pkg::RAM_LO) >> 1);
    status_w = 32'h0000_0000;
    status_w[15:0] = ctl_q;
    status_w[aasq_pkg::B_CAL_BUSY] = st_q == aasq_pkg::ST_CAL;
    status_w[aasq_pkg::B_CUR_LO +: 4] = ch_q;
    rd_d = 32'h0000_0000;
    if (ap_valid_d && !hwrite) begin
      if (rd_ctl) begin
        rd_d = status_w;
      end else if (rd_ram) begin
        rd_d = {16'h0000, ram_q[rd_word]};
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_q <= 32'h0000_0000;
    end else begin
      rd_q <= rd_d;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    hrdata = rd_q;
    hreadyout = 1'b1;
    hresp = 1'b0;
    mux_sel = mux_q;
    adc_hold = hold_q;
    adc_convert = conv_q;
    adc_cal_start = calp_q;
    fmt_twos = ctl_q[aasq_pkg::B_FMT];
    fail_led = ctl_q[aasq_pkg::B_LED];
  end
endmodule

// ---- src/aasq_pkg.sv ----
// Package for the autoscan converter sequencer: offsets, fields, timing.
// Assumes a 200 MHz system clock and an AHB-Lite register bus.
package aasq_pkg;
  // ==========================================================
  // Register map: word indices, byte address is four times the index
  localparam logic [7:0] CTL_LO = 8'h00;
  localparam logic [7:0] CTL_HI = 8'h0E;
  localparam logic [7:0] RAM_LO = 8'h10;
  localparam logic [7:0] RAM_HI = 8'h4E;
  localparam int RAM_WORDS = 32;
  localparam int RES_W = 16;
  // ==========================================================
  // Control fields of control_status_word
  localparam int B_SCAN_EN = 0;
  localparam int B_SIZE8 = 1;
  localparam int B_FMT = 2;
  localparam int B_LED = 3;
  localparam int B_SWRST = 4;
  localparam int B_REPEAT = 5;
  localparam int B_SEL_LO = 8;
  localparam int SEL_W = 4;
  // Status fields
  localparam int B_CAL_BUSY = 16;
  localparam int B_CUR_LO = 20;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  // ==========================================================
  // Timing
  localparam real CLK_NS = 5.0;
  localparam real SLOT_NS = 10050.0;
  localparam int SLOT_CYC = int'(SLOT_NS / CLK_NS);
  localparam real CAL_MS = 41.0;
  localparam int CAL_CYC = int'(CAL_MS * 1.0e6 / CLK_NS);
  localparam real HOLD_NS = 100.0;
  localparam int HOLD_CYC = int'(HOLD_NS / CLK_NS);
  typedef enum logic [2:0] {
    ST_CAL = 3'b001,
    ST_IDLE = 3'b010,
    ST_RUN = 3'b100
  } aasq_state_t;
endpackage

// ---- sim/aasq_adc_model.sv ----
// Converter model: answers each convert strobe with a code built from the
// channel on mux_sel. Assumes mux_sel still holds the sampled channel then.
`timescale 1ns/1ps
module aasq_adc_model (
  // Converter side
  input wire logic clk,
  input wire logic adc_convert,
  input wire logic [3:0] mux_sel,
  output logic [15:0] adc_data
);
  initial adc_data = 16'h0000;
  // Channel in the low nibble so a wrong store slot shows up
  always @(posedge clk) if (adc_convert) adc_data <= {12'hA50, mux_sel};
endmodule

// ---- sim/aasq_top_sva.sv ----
// Checker for the sequencer: strobes, slot timing, calibration, bus replies.
// Assumes the shortened counts that the bench hands over by bind.
`timescale 1ns/1ps
module aasq_top_sva #(
  parameter int CAL_CYCLES = 50,
  parameter int SLOT_CYCLES = 40
) (
  // Watched ports
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [3:0] mux_sel,
  input wire logic adc_hold,
  input wire logic adc_convert,
  input wire logic adc_cal_start
);
  logic [15:0] gap_q, gap_d, cal_q, cal_d;
  logic unm_q, unm_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // Helpers
  always_comb begin
    gap_d = adc_convert ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hFFFF};
    cal_d = adc_cal_start ? 16'h0000 : cal_q + {15'h0000, cal_q != 16'hFFFF};
    unm_d = hsel && hready && htrans[1] && !hwrite && haddr >= 32'h0000_0140
      && haddr < 32'h0000_0200;
  end
  always_ff @(posedge clk) begin
    gap_q <= nrst ? gap_d : 16'hFFFF;
    cal_q <= nrst ? cal_d : 16'h0000;
    unm_q <= nrst && unm_d;
  end
  // ==========================================
  // Properties
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus reply not ready or not okay");
  AST_HOLD_SPAN: assert property ($rose(adc_hold) |-> ##19 adc_hold ##1 !adc_hold)
    else $error("hold span wrong");
  AST_CONV_IN_HOLD: assert property (adc_convert |-> $rose(adc_hold))
    else $error("convert without hold start");
  AST_SLOT_PERIOD: assert property
    (adc_convert |-> gap_q == SLOT_CYCLES - 1 || gap_q > SLOT_CYCLES)
    else $error("slot period wrong");
  AST_CAL_PULSE: assert property ($rose(nrst) |=> adc_cal_start ##1 !adc_cal_start)
    else $error("calibration pulse missing");
  AST_CAL_HOLDOFF: assert property (adc_convert |-> cal_q >= CAL_CYCLES - 2)
    else $error("convert during calibration");
  AST_MUX_STEADY: assert property (adc_convert |=> $stable(mux_sel))
    else $error("mux moved at sample");
  AST_UNMAPPED_ZERO: assert property (unm_q |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  cover property (adc_convert ##40 adc_convert);
  cover property (adc_cal_start);
  cover property (unm_q);
endmodule
bind aasq_top aasq_top_sva #(.CAL_CYCLES(CAL_CYCLES), .SLOT_CYCLES(SLOT_CYCLES)) u_sva (
  .clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .mux_sel, .adc_hold, .adc_convert, .adc_cal_start);

// ---- sim/tb_autoscan_adc_sequencer.sv ----
// Bench: AHB-Lite master tasks drive the sequencer; converter model behind.
// Assumes zero-wait slave replies and shortened counts (cal 50, slot 40).
`timescale 1ns/1ps
module tb_autoscan_adc_sequencer;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready, hreadyout, hresp, adc_hold, adc_convert, adc_cal_start, fmt_twos, fail_led;
  logic [31:0] hrdata, rv;
  logic [3:0] mux_sel;
  logic [15:0] adc_data;
  int bad_count = 0;
  int num_checks = 0;
  assign hready = hreadyout;
  always #2.5 clk = ~clk;
  aasq_top #(.CAL_CYCLES(50), .SLOT_CYCLES(40)) DUT (.clk, .nrst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .mux_sel, .adc_hold,
    .adc_convert, .adc_cal_start, .adc_data, .fmt_twos, .fail_led);
  aasq_adc_model u_adc (.clk, .adc_convert, .mux_sel, .adc_data);
  // ==========================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rv = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk($sformatf("read %h", a), rv & m, e);
  endtask
  function automatic logic [31:0] adr(input int i);
    return 32'h0000_0040 + 32'(i) * 8;
  endfunction
  // Words below n carry results, the rest keep their preset
  task automatic words(input int n, input logic [31:0] pre);
    for (int i = 0; i < 16; i++) rd(adr(i), 32'h0000_FFFF, i < n ? 32'hA500 + i : pre + i);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(32'h00, 32'h0000_FFFF, 32'h0000_0000);
    xfer(1'b1, 32'h38, 32'h0000_000C);
    rd(32'h18, 32'h0000_FFFF, 32'h0000_000C);
    chk("fmt_twos", fmt_twos, 32'h1);
    chk("fail_led", fail_led, 32'h1);
    xfer(1'b1, 32'h180, 32'hFFFF_FFFF);
    rd(32'h180, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int i = 0; i < 32; i++) xfer(1'b1, adr(i), 32'h1200 + i);
    rd(adr(31), 32'h0000_FFFF, 32'h0000_121F);
    xfer(1'b1, 32'h00, 32'h0000_0010);
    rd(32'h00, 32'h0001_FFFF, 32'h0001_0000);
    chk("fail_led", fail_led, 32'h0);
    // Enabled while still calibrating: first convert must wait
    xfer(1'b1, 32'h00, 32'h0000_0003);
    repeat (600) @(posedge clk);
    words(8, 32'h1200);
    xfer(1'b1, 32'h00, 32'h0000_0001);
    repeat (800) @(posedge clk);
    words(16, 32'h1200);
    xfer(1'b1, 32'h00, 32'h0000_0000);
    repeat (100) @(posedge clk);
    for (int i = 0; i < 16; i++) xfer(1'b1, adr(i), 32'h0000_0000);
    xfer(1'b1, 32'h00, 32'h0000_0520);
    repeat (200) @(posedge clk);
    for (int i = 4; i < 7; i++) rd(adr(i), 32'h0000_FFFF, i == 5 ? 32'hA505 : 32'h0);
    complete_run;
  end
endmodule
